// ===== hdl/xpt_pkg.sv
// Purpose: Shared constants for the crosspoint I2C link, both ends
// Assumes: 8 columns, 10 rows, 7-bit slave address
// Notes: Row codes feed the switch-write decoder
package xpt_pkg;
  localparam logic [6:0] slave_addr = 7'h70; // Arbitrary default address
  localparam int num_rows = 10;
  localparam int num_cols = 8;
  localparam logic [7:0] rb_code [0:9] = '{8'h74, 8'h7C, 8'h35, 8'h3D, 8'h75,
                                           8'h7D, 8'h36, 8'h3E, 8'h76, 8'h7E};
  localparam logic [7:0] status_hi = 8'h00;
  localparam logic [79:0] switch_reset = 80'h0000_0000_0000_0000_0000;
  localparam logic [7:0] status_reset = 8'h00;
  localparam int data_msb = 7;
  localparam int row_lsb = 3;
  localparam int col_lsb = 0;
  // Switch-write row codes per row; codes 0, 1, 6, 7, 14, 15 are reserved
  localparam logic [3:0] row_code [0:9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
                                           4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  localparam logic [7:0] half_div = 8'h06; // Divider end count, half period is one mclk more
  localparam logic [3:0] bit_count_full = 4'h8;
endpackage

// ===== hdl/xpt_link_if.sv
// Purpose: I2C wires between the crosspoint device end and the master end
// Assumes: Open-drain data line, master drives the clock
// Notes: Wire level resolved here from the enables
`timescale 1ns/1ps
interface xpt_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // Open-drain resolve: any enable pulls low
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface

// ===== hdl/xpt_device.sv
// What this block does
// - Address byte with R/W, device acks low
// - Write carries two bytes, each acked
// - Write changes only the selected switch
// - Readback reports any row of eight
// - Readback select is two-byte write
// - Select write captures row into status
// - Master rereads with R/W set
// - Read returns zero byte then status
// - Status bit one means switch closed
// - Readback codes decode to rows
// - First byte: on/off, row, column
//
// Purpose: I2C slave front end of the 8 x 10 crosspoint array
// Assumes: Runs on the link clock; srst is synchronous to it
// Notes: Start/stop seen by sampling sda on the link clock
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module xpt_device
  import xpt_pkg::*;
(
  input wire logic lclk,
  input wire logic srst,
  input wire logic ce,
  xpt_link_if.device link,
  output logic [79:0] switch_state,
  output logic [7:0] status_reg
);
  typedef enum {st_idle, st_addr, st_ack_addr, st_wr, st_ack_wr, st_rd, st_ack_rd} dev_state_t;
  dev_state_t state;
  logic scl_s1;
  logic scl_s;
  logic sda_s1;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] first_byte;
  logic [7:0] tx_byte;
  logic ack_drive;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rx_next;
  logic [3:0] row_sel;
  logic [2:0] col_sel;
  logic [3:0] rb_row;
  logic rb_hit;
  logic [3:0] wr_row;
  logic wr_hit;

  //////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, then one stage for edge and condition detection
  always_ff @(posedge lclk) begin
    if (srst) begin
      scl_s1 <= 1'b1;
      scl_s <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_s1 <= link.scl;
      scl_s <= scl_s1;
      sda_s1 <= link.sda;
      sda_s <= sda_s1;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_seen = scl_s && scl_q && sda_q && !sda_s;
  assign stop_seen = scl_s && scl_q && !sda_q && sda_s;
  assign rx_next = {shift[6:0], sda_s};
  assign row_sel = first_byte[data_msb-1:row_lsb];
  assign col_sel = first_byte[row_lsb-1:col_lsb];

  // Readback code to row decode
  always_comb begin
    rb_hit = 1'b0;
    rb_row = 4'h0;
    for (int i = 0; i < num_rows; i++) begin
      if (first_byte == rb_code[i]) begin
        rb_hit = 1'b1;
        rb_row = 4'(i);
      end
    end
  end

  // Switch-write row code to row decode, gaps in the code space are reserved
  always_comb begin
    wr_hit = 1'b0;
    wr_row = 4'h0;
    for (int i = 0; i < num_rows; i++) begin
      if (row_sel == row_code[i]) begin
        wr_hit = 1'b1;
        wr_row = 4'(i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Protocol state machine
  always_ff @(posedge lclk) begin
    if (srst) begin
      state <= st_idle;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      byte_cnt <= 2'd0;
      first_byte <= 8'h00;
      ack_drive <= 1'b0;
    end else if (ce) begin
      if (start_seen) begin
        state <= st_addr;
        bit_cnt <= 4'h0;
        byte_cnt <= 2'd0;
        ack_drive <= 1'b0;
      end else if (stop_seen) begin
        state <= st_idle;
        ack_drive <= 1'b0;
      end else begin
        case (state)
          st_idle: begin
            ack_drive <= 1'b0;
          end
          st_addr: begin
            if (scl_rise) begin
              shift <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == bit_count_full) begin
              bit_cnt <= 4'h0;
              if (shift[7:1] == slave_addr) begin
                ack_drive <= 1'b1;
                state <= st_ack_addr;
              end else begin
                state <= st_idle;
              end
            end
          end
          st_ack_addr: begin
            if (scl_fall) begin
              ack_drive <= 1'b0;
              byte_cnt <= 2'd0;
              state <= shift[0] ? st_rd : st_wr;
            end
          end
          st_wr: begin
            if (scl_rise) begin
              shift <= rx_next;
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == bit_count_full) begin
              bit_cnt <= 4'h0;
              if (byte_cnt == 2'd0) begin
                first_byte <= shift;
              end
              ack_drive <= (byte_cnt != 2'd2);
              state <= st_ack_wr;
            end
          end
          st_ack_wr: begin
            if (scl_fall) begin
              ack_drive <= 1'b0;
              byte_cnt <= (byte_cnt == 2'd2) ? 2'd2 : byte_cnt + 2'd1;
              state <= st_wr;
            end
          end
          st_rd: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                state <= st_ack_rd;
              end
            end
          end
          st_ack_rd: begin
            if (scl_rise && sda_s) begin
              state <= st_idle; // Master refused more data
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              byte_cnt <= byte_cnt + 2'd1;
              state <= st_rd; // Next byte starts only once the clock is low
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Switch array and status capture, applied after the second byte ack
  always_ff @(posedge lclk) begin
    if (srst) begin
      switch_state <= switch_reset;
      status_reg <= status_reset;
    end else if (ce && state == st_ack_wr && scl_fall && byte_cnt == 2'd1) begin
      if (rb_hit) begin
        for (int c = 0; c < num_cols; c++) begin
          status_reg[c] <= switch_state[rb_row*num_cols + c];
        end
      end else if (wr_hit) begin
        switch_state[wr_row*num_cols + col_sel] <= first_byte[data_msb];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit byte: zeros first, then captured status
  always_comb begin
    tx_byte = (byte_cnt == 2'd0) ? status_hi : status_reg;
  end

  // Open-drain drive: ack low, or a read bit of zero
  always_comb begin
    link.sda_s_o = 1'b0;
    link.sda_s_oe = ack_drive;
    if (state == st_rd && byte_cnt < 2'd2) begin
      link.sda_s_oe = !tx_byte[3'd7 - bit_cnt[2:0]];
    end
  end
endmodule

// ===== hdl/xpt_master.sv
// Purpose: I2C master end driving the crosspoint link from a register port
// Assumes: Link clock derived from mclk by a divider
// Notes: Regs 0 cmd/go, 1 byte0, 2 byte1, 3 status, 4 read data
`timescale 1ns/1ps
module xpt_master
  import xpt_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  xpt_link_if.master link
);
  typedef enum {m_idle, m_start, m_bit, m_ack, m_stop, m_release} m_state_t;
  m_state_t state;
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [15:0] rx;
  logic [7:0] cur;
  logic [2:0] bidx;
  logic [1:0] nbyte;
  logic is_read;
  logic busy;
  logic nack;
  logic [7:0] div;
  logic phase;
  logic tick;
  logic sda_s1;
  logic sda_s2;

  //////////////////////////////////////////////////////////////////////
  // Synchroniser for the returned data line
  always_ff @(posedge mclk) begin
    if (srst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else if (ce) begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  // Clock divider tick, two ticks per bit
  always_ff @(posedge mclk) begin
    if (srst || !busy) begin
      div <= 8'h00;
    end else if (ce) begin
      div <= (div == half_div) ? 8'h00 : div + 8'h01;
    end
  end
  assign tick = busy && (div == half_div);

  //////////////////////////////////////////////////////////////////////
  // Register port: write 0 starts (bit0 = read), 1/2 hold data bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      byte0 <= 8'h00;
      byte1 <= 8'h00;
    end else if (ce && wr && !busy) begin
      if (addr == 3'd1) begin
        byte0 <= wdata;
      end else if (addr == 3'd2) begin
        byte1 <= wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (ce && rd) begin
      if (addr == 3'd3) begin
        rdata <= {14'h0000, nack, busy};
      end else if (addr == 3'd4) begin
        rdata <= rx;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transfer engine: address byte, then two data bytes out or in
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= m_idle;
      busy <= 1'b0;
      nack <= 1'b0;
      is_read <= 1'b0;
      link.scl <= 1'b1;
      link.sda_m_oe <= 1'b0;
      phase <= 1'b0;
      cur <= 8'h00;
      bidx <= 3'd7;
      nbyte <= 2'd0;
      rx <= 16'h0000;
    end else if (ce) begin
      if (state == m_idle) begin
        if (wr && addr == 3'd0) begin
          busy <= 1'b1;
          nack <= 1'b0;
          is_read <= wdata[0];
          cur <= {slave_addr, wdata[0]};
          state <= m_start;
        end
      end else if (tick) begin
        phase <= !phase;
        case (state)
          m_start: begin
            link.sda_m_oe <= 1'b1;
            state <= m_bit;
            bidx <= 3'd7;
            nbyte <= 2'd0;
            phase <= 1'b0;
          end
          m_bit: begin
            if (!phase) begin
              link.scl <= 1'b0;
              link.sda_m_oe <= (is_read && nbyte != 2'd0) ? 1'b0 : !cur[bidx];
            end else begin
              link.scl <= 1'b1;
              if (is_read && nbyte != 2'd0) begin
                rx <= {rx[14:0], sda_s2};
              end
              if (bidx == 3'd0) begin
                state <= m_ack;
              end
              bidx <= bidx - 3'd1;
            end
          end
          m_ack: begin
            if (!phase) begin
              link.scl <= 1'b0;
              link.sda_m_oe <= is_read && nbyte == 2'd1; // Master acks first read byte
            end else begin
              link.scl <= 1'b1;
              if (!(is_read && nbyte != 2'd0) && sda_s2) begin
                nack <= 1'b1;
              end
              if (nbyte == 2'd2) begin
                state <= m_stop;
              end else begin
                nbyte <= nbyte + 2'd1;
                cur <= (nbyte == 2'd0) ? byte0 : byte1;
                state <= m_bit;
              end
            end
          end
          m_stop: begin
            if (!phase) begin
              link.scl <= 1'b0;
              link.sda_m_oe <= 1'b1;
            end else begin
              link.scl <= 1'b1;
              state <= m_release;
            end
          end
          m_release: begin
            link.sda_m_oe <= 1'b0; // Stop: data rises a half period after the clock
            state <= m_idle;
            busy <= 1'b0;
          end
          default: state <= m_idle;
        endcase
      end
      if (state == m_idle && !busy) begin
        link.sda_m_oe <= 1'b0;
      end
    end
  end
  assign link.sda_m_o = 1'b0;
endmodule

// ===== test/xpt_link_checker.sv
// Purpose: Wire checks on the crosspoint link
// Assumes: lclk samples much faster than scl
// Notes: Instantiated beside the link interface
`timescale 1ns/1ps
module xpt_link_checker (
  input wire logic mclk,
  input wire logic lclk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic [4:0] high_cnt;
  ////////////////////////////////////////////////////////////
  // Length of the current high stretch of scl
  always_ff @(posedge lclk) begin
    if (srst || !scl) begin
      high_cnt <= 5'h00;
    end else if (high_cnt != 5'h1f) begin
      high_cnt <= high_cnt + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  // Device side of the data line
  AST_ACK_ON_LOW: assert property (@(posedge lclk) disable iff (srst) $rose(sda_s_oe) |-> !scl)
    else $error("device took sda while scl high");
  AST_HOLD_ON_HIGH: assert property (@(posedge lclk) disable iff (srst) scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device moved sda while scl high");
  AST_PULL_ONLY: assert property (@(posedge lclk) disable iff (srst) sda_s_oe |-> !sda_s_o)
    else $error("device drove sda high");
  AST_ACK_SEEN: assert property (@(posedge lclk) disable iff (srst) $rose(sda_s_oe) |-> ##[1:10] (scl && !sda))
    else $error("low bit not held into scl high");
  AST_DRIVE_BOUND: assert property (@(posedge lclk) disable iff (srst) $rose(sda_s_oe) |-> ##[1:150] !sda_s_oe)
    else $error("device held sda too long");
  AST_IDLE_QUIET: assert property (@(posedge lclk) disable iff (srst) high_cnt > 5'h0c |-> !sda_s_oe)
    else $error("device drove sda on idle bus");
  // Master clock halves
  AST_SCL_HIGH_HALF: assert property (@(posedge mclk) disable iff (srst) $rose(scl) |=> scl[*3])
    else $error("scl high half too short");
  AST_SCL_LOW_HALF: assert property (@(posedge mclk) disable iff (srst) $fell(scl) |=> !scl[*3])
    else $error("scl low half too short");
endmodule

// ===== test/xpt_link_tb.sv
// Purpose: Master and device ends joined, driven from the register port
// Assumes: Register map 0 go, 1 byte0, 2 byte1, 3 status, 4 read data
// Notes: Second byte of a switch write is a don't care
`timescale 1ns/1ps
module xpt_link_tb;
  import xpt_pkg::*;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] rv;
  logic [79:0] switch_state;
  logic [7:0] status_reg;
  logic [79:0] model = switch_reset;
  int rows [6] = '{0, 9, 4, 4, 5, 4};
  int cols [6] = '{0, 7, 3, 7, 0, 3};
  logic ons [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  xpt_link_if link ();
  xpt_master u_xpt_master (.mclk(mclk), .srst(srst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(link.master));
  xpt_device u_xpt_device (.lclk(lclk), .srst(srst), .ce(1'b1), .link(link.device),
    .switch_state(switch_state), .status_reg(status_reg));
  xpt_link_checker u_xpt_link_checker (.mclk(mclk), .lclk(lclk), .srst(srst), .scl(link.scl), .sda(link.sda),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
  ////////////////////////////////////////////////////////////
  // Clocks, rising edges of the two never coincide
  always #20 mclk = ~mclk;
  always #24 lclk = ~lclk;
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask
  // Full transfer, then poll busy and check no nack
  task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input logic rw);
    int i;
    wr_reg(3'h1, b0);
    wr_reg(3'h2, b1);
    wr_reg(3'h0, {7'h00, rw});
    wr_reg(3'h1, ~b0); // Ignored while busy
    rv = 16'h0001;
    for (i = 0; i < 3000 && rv[0] !== 1'b0; i++) begin
      rd_reg(3'h3, rv);
    end
    chk({79'h0, rv[0]}, 80'h0);
    chk({79'h0, rv[1]}, 80'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk(switch_state, switch_reset);
    chk({72'h0, status_reg}, {72'h0, status_reset});
    $display("test reset done");
    // Single switch writes, last one turns a switch off
    for (int k = 0; k < 6; k++) begin
      xfer({ons[k], row_code[rows[k]], 3'(cols[k])}, 8'h5A, 1'b0);
      model[rows[k] * 8 + cols[k]] = ons[k];
      chk(switch_state, model);
    end
    $display("test switch_writes done");
    // Reserved row codes and unmapped registers change nothing
    xfer(8'h80, 8'h00, 1'b0);
    xfer(8'h8F, 8'h00, 1'b0);
    xfer(8'hF0, 8'h00, 1'b0);
    xfer(8'hB8, 8'h00, 1'b0);
    wr_reg(3'h7, 8'hFF);
    rd_reg(3'h5, rv);
    chk({64'h0, rv}, 80'h0);
    chk(switch_state, model);
    $display("test reserved done");
    // Readback of every row
    for (int r = 0; r < num_rows; r++) begin
      xfer(rb_code[r], 8'hA5, 1'b0);
      chk({72'h0, status_reg}, {72'h0, model[r * 8 +: 8]});
      xfer(8'h00, 8'h00, 1'b1);
      rd_reg(3'h4, rv);
      chk({64'h0, rv}, {64'h0, status_hi, model[r * 8 +: 8]});
    end
    chk(switch_state, model);
    $display("test readback done");
    end_sim();
  end
endmodule
